// *** core/counter_array_pkg.sv ***
// constants, layouts and types shared by the counter array watchdog
package counter_array_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CTRL = 8'hD8;
   localparam logic [7:0] IDX_MODE = 8'hD9;
   localparam logic [7:0] IDX_CPM4 = 8'hDE;
   localparam logic [7:0] IDX_CNT_LO = 8'hF9;
   localparam logic [7:0] IDX_CNT_HI = 8'hFA;
   localparam logic [7:0] IDX_OFFSET = 8'hFD;
   localparam logic [7:0] IDX_UPDATE = 8'hFE;
   localparam int ADDR_W = 10;
   localparam logic [1:0] WORD_LSB = 2'h0;

   // control/flag register fields
   localparam int CTRL_OVF = 7;
   localparam int CTRL_RUN = 6;
   localparam int CTRL_UNUSED = 5;
   localparam int CTRL_MODULE4_MATCH_FLAG = 4;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // module 4 mode register fields
   localparam int CPM_ECOM = 6;
   localparam int CPM_MAT = 3;
   localparam int CPM_ECCF = 0;
   localparam logic [7:0] CPM_RESET = 8'h00;
   // software timer: comparator and match on
   localparam logic [7:0] CPM_SW_TIMER = 8'h48;

   localparam logic [7:0] MODE_RESET = 8'h40;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_FULL = 8'hFF;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [15:0] CNT_LAST = 16'hFFFF;

   // counter clock sources
   localparam logic [2:0] CS_DIV12 = 3'h0;
   localparam logic [2:0] CS_DIV4 = 3'h1;
   localparam logic [2:0] CS_TIMER0 = 3'h2;
   localparam logic [2:0] CS_EXT_FALL = 3'h3;
   localparam logic [2:0] CS_SYSCLK = 3'h4;
   localparam logic [2:0] CS_EXT_DIV8 = 3'h5;
   localparam logic [3:0] DIV12_LAST = 4'hB;
   localparam logic [3:0] PRESC_RESET = 4'h0;
   localparam logic [1:0] DIV4_LAST = 2'h3;
   localparam logic [2:0] DIV8_LAST = 3'h7;
   localparam logic [2:0] DIV8_RESET = 3'h0;

   // mode register layout, bit 7 down to bit 0
   typedef struct packed {
      logic idle_suspend;
      logic watchdog_enable;
      logic watchdog_lock;
      logic unused;
      logic [2:0] counter_clock_select;
      logic overflow_irq_en;
   } mode_s;
endpackage

// *** core/counter_array_watchdog.sv ***
// counter array with module 4 watchdog behind an apb slave
`timescale 1ns/1ns
module counter_array_watchdog (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [counter_array_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic cpu_idle,
   input wire logic timer0_overflow,
   input wire logic [3:0] module_hit,
   input wire logic [3:0] module_irq_en,
   input wire logic ext_count_pin,
   input wire logic ext_clock_pin,
   output logic array_irq,
   output logic watchdog_reset_req
);
   logic rst_meta_r;
   logic rst_sync_b;
   logic [1:0] pin_meta_r;
   logic [1:0] pin_sync_r;
   logic [1:0] pin_last_r;

   logic [7:0] ctrl_r;
   logic [7:0] ctrl_nxt;
   counter_array_pkg::mode_s mode_r;
   counter_array_pkg::mode_s mode_nxt;
   logic [7:0] cpm4_r;
   logic [7:0] cpm4_nxt;
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   logic [7:0] snap_r;
   logic [7:0] snap_nxt;
   logic [7:0] offset_r;
   logic [7:0] offset_nxt;
   logic [7:0] update_r;
   logic [7:0] update_nxt;
   logic [3:0] presc_r;
   logic [3:0] presc_nxt;
   logic [2:0] div8_r;
   logic [2:0] div8_nxt;
   logic [31:0] prdata_nxt;
   logic pready_nxt;
   logic pslverr_nxt;
   logic irq_nxt;
   logic wdr_nxt;

   logic wdt_on;
   logic run;
   logic tick;
   logic low_wrap;
   logic [7:0] cpm4_eff;
   logic [7:0] idx;
   logic mapped;
   logic rd_setup;
   logic acc;
   logic wr;
   logic rd;
   logic [7:0] wb;
   logic [7:0] rd_byte;
   logic expire;
   logic force_rst;
   logic m4_match;
   logic ext_fall;
   logic ext_rise;
   counter_array_pkg::mode_s wb_mode;

   // async assert, synchronous release
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_r <= 1'b0;
         rst_sync_b <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_sync_b <= rst_meta_r;
      end
   end

   // two-flop synchronisers for the external count pins
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_pin
         always_ff @(posedge clk or negedge rst_sync_b) begin
            if (!rst_sync_b) begin
               pin_meta_r[gi] <= 1'b0;
               pin_sync_r[gi] <= 1'b0;
               pin_last_r[gi] <= 1'b0;
            end else begin
               pin_meta_r[gi] <= gi == 0 ? ext_count_pin : ext_clock_pin;
               pin_sync_r[gi] <= pin_meta_r[gi];
               pin_last_r[gi] <= pin_sync_r[gi];
            end
         end
      end
   endgenerate

   assign ext_fall = pin_last_r[0] & ~pin_sync_r[0];
   assign ext_rise = pin_sync_r[1] & ~pin_last_r[1];

   // enable or lock turns the watchdog on
   assign wdt_on = mode_r.watchdog_enable | mode_r.watchdog_lock;
   // forced running; run control; idle suspend
   assign run = (ctrl_r[counter_array_pkg::CTRL_RUN] | wdt_on) & ~(mode_r.idle_suspend & cpu_idle);

   // counter clock selection, divide by 12 by default
   always_comb begin
      unique case (mode_r.counter_clock_select)
         counter_array_pkg::CS_DIV12: tick = presc_r == counter_array_pkg::DIV12_LAST;
         counter_array_pkg::CS_DIV4: tick = presc_r[1:0] == counter_array_pkg::DIV4_LAST;
         counter_array_pkg::CS_TIMER0: tick = timer0_overflow;
         counter_array_pkg::CS_EXT_FALL: tick = ext_fall;
         counter_array_pkg::CS_SYSCLK: tick = 1'b1;
         counter_array_pkg::CS_EXT_DIV8: tick = ext_rise & (div8_r == counter_array_pkg::DIV8_LAST);
         default: tick = 1'b0;
      endcase
   end

   assign low_wrap = run & tick & (cnt_r[7:0] == counter_array_pkg::BYTE_FULL);
   // module 4 is a software timer while the watchdog runs
   assign cpm4_eff = wdt_on ? counter_array_pkg::CPM_SW_TIMER : cpm4_r;
   // expiry: low byte wraps while update byte equals counter high
   assign expire = wdt_on & low_wrap & (update_r == cnt_r[15:8]);
   assign m4_match = ~wdt_on & cpm4_eff[counter_array_pkg::CPM_ECOM] & cpm4_eff[counter_array_pkg::CPM_MAT]
      & run & tick & (cnt_r == {update_r, offset_r});

   // apb decode; one wait state, effects at the edge that samples pready
   assign idx = paddr[counter_array_pkg::ADDR_W-1:2];
   assign mapped = paddr[1:0] == counter_array_pkg::WORD_LSB
      && (idx == counter_array_pkg::IDX_CTRL || idx == counter_array_pkg::IDX_MODE
      || idx == counter_array_pkg::IDX_CPM4 || idx == counter_array_pkg::IDX_CNT_LO
      || idx == counter_array_pkg::IDX_CNT_HI || idx == counter_array_pkg::IDX_OFFSET
      || idx == counter_array_pkg::IDX_UPDATE);
   assign rd_setup = psel & penable & ~pready;
   assign acc = psel & penable & pready & mapped;
   assign wr = acc & pwrite;
   assign rd = acc & ~pwrite;
   assign wb = pwdata[7:0];
   assign wb_mode = wb;
   // writing 1 to the module 4 flag forces a reset while the watchdog is on
   assign force_rst = wdt_on & wr & (idx == counter_array_pkg::IDX_CTRL) & wb[counter_array_pkg::CTRL_MODULE4_MATCH_FLAG];

   always_comb begin
      unique case (idx)
         // run control reads only the software copy; bit 5 reads zero
         counter_array_pkg::IDX_CTRL: rd_byte = ctrl_r;
         counter_array_pkg::IDX_MODE: rd_byte = mode_r;
         counter_array_pkg::IDX_CPM4: rd_byte = cpm4_eff;
         counter_array_pkg::IDX_CNT_LO: rd_byte = cnt_r[7:0];
         counter_array_pkg::IDX_CNT_HI: rd_byte = snap_r;
         counter_array_pkg::IDX_OFFSET: rd_byte = offset_r;
         counter_array_pkg::IDX_UPDATE: rd_byte = update_r;
         default: rd_byte = counter_array_pkg::BYTE_ZERO;
      endcase
   end

   always_comb begin
      ctrl_nxt = ctrl_r;
      mode_nxt = mode_r;
      cpm4_nxt = cpm4_r;
      cnt_nxt = cnt_r;
      snap_nxt = snap_r;
      offset_nxt = offset_r;
      update_nxt = update_r;
      presc_nxt = presc_r == counter_array_pkg::DIV12_LAST ? counter_array_pkg::PRESC_RESET : presc_r + 4'h1;
      div8_nxt = ext_rise ? div8_r + 3'h1 : div8_r;
      pready_nxt = psel & penable & ~pready;
      pslverr_nxt = rd_setup & ~mapped;
      prdata_nxt = prdata;
      if (rd_setup) begin
         prdata_nxt = {24'h000000, mapped ? rd_byte : counter_array_pkg::BYTE_ZERO};
      end
      if (rd && idx == counter_array_pkg::IDX_CNT_LO) begin
         snap_nxt = cnt_r[15:8];
      end
      if (run && tick) begin
         cnt_nxt = cnt_r + 16'h0001;
      end
      if (wr) begin
         unique case (idx)
            counter_array_pkg::IDX_CTRL: begin
               // stored only; the watchdog overrides the running state
               ctrl_nxt[counter_array_pkg::CTRL_RUN] = wb[counter_array_pkg::CTRL_RUN];
               ctrl_nxt[counter_array_pkg::CTRL_OVF] = wb[counter_array_pkg::CTRL_OVF];
               ctrl_nxt[3:0] = wb[3:0];
               if (!wdt_on) begin
                  ctrl_nxt[counter_array_pkg::CTRL_MODULE4_MATCH_FLAG] = wb[counter_array_pkg::CTRL_MODULE4_MATCH_FLAG];
               end
            end
            counter_array_pkg::IDX_MODE: begin
               // clock select and idle suspend frozen while on
               if (!wdt_on) begin
                  mode_nxt.idle_suspend = wb_mode.idle_suspend;
                  mode_nxt.counter_clock_select = wb_mode.counter_clock_select;
               end
               // lock is sticky; unlocked enable clear turns it off
               mode_nxt.watchdog_lock = mode_r.watchdog_lock | wb_mode.watchdog_lock;
               mode_nxt.watchdog_enable = wb_mode.watchdog_enable;
               mode_nxt.overflow_irq_en = wb_mode.overflow_irq_en;
            end
            counter_array_pkg::IDX_CPM4: begin
               if (!wdt_on) begin
                  cpm4_nxt = wb;
               end
            end
            counter_array_pkg::IDX_CNT_LO: begin
               if (!wdt_on) begin
                  cnt_nxt[7:0] = wb;
               end
            end
            counter_array_pkg::IDX_CNT_HI: begin
               if (!wdt_on) begin
                  cnt_nxt[15:8] = wb;
               end
            end
            counter_array_pkg::IDX_OFFSET: begin
               offset_nxt = wb;
               if (!wdt_on) begin
                  cpm4_nxt[counter_array_pkg::CPM_ECOM] = 1'b0;
               end
            end
            counter_array_pkg::IDX_UPDATE: begin
               // refresh loads counter high plus offset
               if (wdt_on) begin
                  update_nxt = cnt_r[15:8] + offset_r;
               end else begin
                  update_nxt = wb;
                  cpm4_nxt[counter_array_pkg::CPM_ECOM] = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
      // overflow flag; set wins over a clear in the same cycle
      if (run && tick && cnt_r == counter_array_pkg::CNT_LAST) begin
         ctrl_nxt[counter_array_pkg::CTRL_OVF] = 1'b1;
      end
      // hardware sets match flags; only software clears them
      ctrl_nxt[3:0] = ctrl_nxt[3:0] | module_hit;
      if (m4_match) begin
         ctrl_nxt[counter_array_pkg::CTRL_MODULE4_MATCH_FLAG] = 1'b1;
      end
      ctrl_nxt[counter_array_pkg::CTRL_UNUSED] = 1'b0;
      irq_nxt = (ctrl_r[counter_array_pkg::CTRL_OVF] & mode_r.overflow_irq_en)
         | (ctrl_r[counter_array_pkg::CTRL_MODULE4_MATCH_FLAG] & cpm4_eff[counter_array_pkg::CPM_ECCF])
         | (|(ctrl_r[3:0] & module_irq_en));
      wdr_nxt = expire | force_rst;
   end

   always_ff @(posedge clk or negedge rst_sync_b) begin
      if (!rst_sync_b) begin
         ctrl_r <= counter_array_pkg::CTRL_RESET;
         // enable set, lock clear at reset
         mode_r <= counter_array_pkg::MODE_RESET;
         cpm4_r <= counter_array_pkg::CPM_RESET;
         cnt_r <= counter_array_pkg::CNT_RESET;
         snap_r <= counter_array_pkg::BYTE_ZERO;
         offset_r <= counter_array_pkg::BYTE_ZERO;
         update_r <= counter_array_pkg::BYTE_ZERO;
         presc_r <= counter_array_pkg::PRESC_RESET;
         div8_r <= counter_array_pkg::DIV8_RESET;
         prdata <= 32'h00000000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         array_irq <= 1'b0;
         watchdog_reset_req <= 1'b0;
      end else begin
         ctrl_r <= ctrl_nxt;
         mode_r <= mode_nxt;
         cpm4_r <= cpm4_nxt;
         cnt_r <= cnt_nxt;
         snap_r <= snap_nxt;
         offset_r <= offset_nxt;
         update_r <= update_nxt;
         presc_r <= presc_nxt;
         div8_r <= div8_nxt;
         prdata <= prdata_nxt;
         pready <= pready_nxt;
         pslverr <= pslverr_nxt;
         array_irq <= irq_nxt;
         watchdog_reset_req <= wdr_nxt;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_sync_b);

   sequence s_expire;
      wdt_on && low_wrap && update_r == cnt_r[15:8];
   endsequence
   sequence s_req_pulse;
      watchdog_reset_req ##1 !watchdog_reset_req || wdr_nxt;
   endsequence

   chk_expiry_pulse: assert property (s_expire |=> s_req_pulse)
      else $error("expiry did not raise reset request");
   chk_force_reset: assert property (force_rst |=> watchdog_reset_req)
      else $error("flag write did not force reset");
   chk_counter_forced: assert property (wdt_on && !(mode_r.idle_suspend && cpu_idle) |-> run)
      else $error("counter stopped while watchdog on");
   chk_count_locked: assert property (wdt_on && wr && idx == counter_array_pkg::IDX_CNT_LO && !(run && tick)
      |=> cnt_r == $past(cnt_r))
      else $error("counter changed by write while watchdog on");
   chk_select_frozen: assert property (wdt_on |=> mode_r.counter_clock_select == $past(mode_r.counter_clock_select)
      && mode_r.idle_suspend == $past(mode_r.idle_suspend))
      else $error("clock select or idle suspend changed while on");
   chk_mode4_frozen: assert property (wdt_on |=> cpm4_r == $past(cpm4_r))
      else $error("module 4 mode changed while watchdog on");
   chk_run_readback: assert property (rd_setup && mapped && idx == counter_array_pkg::IDX_CTRL && wdt_on
      && !ctrl_r[counter_array_pkg::CTRL_RUN] |=> !prdata[counter_array_pkg::CTRL_RUN] && pready)
      else $error("run control read back set");
   chk_update_load: assert property (wdt_on && wr && idx == counter_array_pkg::IDX_UPDATE
      |=> update_r == 8'($past(cnt_r[15:8]) + $past(offset_r)))
      else $error("update register not loaded with high plus offset");
   chk_lock_sticky: assert property (mode_r.watchdog_lock |=> mode_r.watchdog_lock && wdt_on)
      else $error("lock released before reset");
   chk_unused_bit: assert property (pready && !pwrite |-> !(idx == counter_array_pkg::IDX_CTRL
      && prdata[counter_array_pkg::CTRL_UNUSED]))
      else $error("unused control bit read as one");
   chk_overflow_flag: assert property (run && tick && cnt_r == counter_array_pkg::CNT_LAST
      |=> ctrl_r[counter_array_pkg::CTRL_OVF])
      else $error("overflow flag not set on wrap");
   chk_disable: assert property (!mode_r.watchdog_lock && wr && idx == counter_array_pkg::IDX_MODE
      && !wb_mode.watchdog_enable && !wb_mode.watchdog_lock |=> !wdt_on)
      else $error("watchdog not disabled by clearing enable");
   chk_offset_write: assert property (wr && idx == counter_array_pkg::IDX_OFFSET |=> offset_r == $past(wb))
      else $error("offset byte not loaded by write");
   chk_flag_sticky: assert property (!(wr && idx == counter_array_pkg::IDX_CTRL)
      |=> (ctrl_r[3:0] & $past(ctrl_r[3:0])) == $past(ctrl_r[3:0]))
      else $error("module flag cleared without software write");
   chk_idle_stop: assert property (mode_r.idle_suspend && cpu_idle
      && !(wr && (idx == counter_array_pkg::IDX_CNT_LO || idx == counter_array_pkg::IDX_CNT_HI))
      |=> cnt_r == $past(cnt_r))
      else $error("counter moved while idle suspended");
   chk_irq_follows: assert property (ctrl_r[counter_array_pkg::CTRL_OVF] && mode_r.overflow_irq_en
      |=> array_irq)
      else $error("overflow flag did not raise interrupt");
   chk_force_nostore: assert property (force_rst
      |=> ctrl_r[counter_array_pkg::CTRL_MODULE4_MATCH_FLAG] == $past(ctrl_r[counter_array_pkg::CTRL_MODULE4_MATCH_FLAG]))
      else $error("forcing write stored module 4 flag");
endmodule

// *** dv/counter_array_watchdog_tb.sv ***
// self-checking bench for the counter array watchdog over apb
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module counter_array_watchdog_tb;
   localparam logic [7:0] CT = counter_array_pkg::IDX_CTRL;
   localparam logic [7:0] MD = counter_array_pkg::IDX_MODE;
   localparam logic [7:0] CM = counter_array_pkg::IDX_CPM4;
   localparam logic [7:0] LO = counter_array_pkg::IDX_CNT_LO;
   localparam logic [7:0] HI = counter_array_pkg::IDX_CNT_HI;
   localparam logic [7:0] OF = counter_array_pkg::IDX_OFFSET;
   localparam logic [7:0] UP = counter_array_pkg::IDX_UPDATE;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [counter_array_pkg::ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic cpu_idle = 1'b0;
   logic [3:0] module_hit = 4'h0;
   logic [3:0] module_irq_en = 4'h0;
   logic array_irq;
   logic watchdog_reset_req;
   int fail_count = 0;
   int comparisons = 0;
   int cyc = 0;
   int req_count = 0;
   int rel_cyc = 0;

   counter_array_watchdog DUT (
      .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_idle(cpu_idle),
      .timer0_overflow(1'b0), .module_hit(module_hit), .module_irq_en(module_irq_en),
      .ext_count_pin(1'b0), .ext_clock_pin(1'b0), .array_irq(array_irq),
      .watchdog_reset_req(watchdog_reset_req)
   );

   initial begin
      forever #2 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc++;
      if (watchdog_reset_req === 1'b1) begin
         req_count++;
      end
   end

   task automatic summarize();
      $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic do_reset();
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      rel_cyc = cyc;
      repeat (2) @(posedge clk);
   endtask

   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, wd};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         fail_count++;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      xfer(1'b1, idx, d, r, e);
   endtask

   task automatic rd(input logic [7:0] idx, output logic [7:0] v);
      logic [31:0] r;
      logic e;
      xfer(1'b0, idx, 8'h00, r, e);
      v = r[7:0];
   endtask

   task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
      logic [31:0] r;
      logic e;
      xfer(1'b0, idx, 8'h00, r, e);
      `CHK(r, {24'h000000, exp})
      `CHK(e, 1'b0)
   endtask

   task automatic wait_req(input int lim);
      int s;
      int c0;
      s = cyc;
      c0 = req_count;
      while (req_count == c0 && cyc - s < lim) @(posedge clk);
   endtask

   initial begin
      int el;
      int c0;
      logic [7:0] v1;
      logic [7:0] v2;
      logic [31:0] r;
      logic e;
      do_reset();
      rdchk(MD, 8'h40);
      rdchk(CT, 8'h00);
      rdchk(CM, 8'h48);
      rdchk(OF, 8'h00);
      wr(MD, 8'hC8);
      rdchk(MD, 8'h40);
      wr(CM, 8'h00);
      rdchk(CM, 8'h48);
      wr(HI, 8'h77);
      wr(LO, 8'h00);
      rd(LO, v1);
      rdchk(HI, 8'h00);
      wr(CT, 8'h00);
      rd(LO, v1);
      repeat (12) @(posedge clk);
      rd(LO, v2);
      `CHK(v1 == v2, 1'b0)
      wr(CT, 8'h40);
      rdchk(CT, 8'h40);
      $display("test freeze done");
      c0 = req_count;
      wr(CT, 8'h10);
      repeat (3) @(posedge clk);
      `CHK(req_count - c0, 1)
      do_reset();
      wait_req(4000);
      el = cyc - rel_cyc;
      `CHK(el >= 3072 && el <= 3085, 1'b1)
      $display("test first timeout done, %0d cycles", el);
      do_reset();
      wr(MD, 8'h00);
      c0 = req_count;
      wr(CT, 8'h00);
      wr(LO, 8'hF0);
      wr(HI, 8'hFF);
      rdchk(LO, 8'hF0);
      rdchk(HI, 8'hFF);
      wr(CM, 8'h00);
      rdchk(CM, 8'h00);
      wr(MD, 8'h09);
      wr(CT, 8'h60);
      repeat (40) @(posedge clk);
      rdchk(CT, 8'hC0);
      `CHK(array_irq, 1'b1)
      wr(CT, 8'h00);
      repeat (3) @(posedge clk);
      rdchk(CT, 8'h00);
      `CHK(array_irq, 1'b0)
      module_irq_en <= 4'h1;
      module_hit <= 4'h1;
      @(posedge clk);
      module_hit <= 4'h0;
      repeat (3) @(posedge clk);
      rdchk(CT, 8'h01);
      `CHK(array_irq, 1'b1)
      wr(CT, 8'h00);
      wr(MD, 8'h88);
      cpu_idle <= 1'b1;
      wr(CT, 8'h40);
      rd(LO, v1);
      rd(LO, v2);
      `CHK(v2, v1)
      cpu_idle <= 1'b0;
      rd(LO, v2);
      `CHK(v1 == v2, 1'b0)
      `CHK(req_count - c0, 0)
      $display("test unlocked done");
      do_reset();
      wr(MD, 8'h00);
      wr(MD, 8'h08);
      wr(CT, 8'h00);
      wr(LO, 8'h00);
      wr(HI, 8'h00);
      wr(OF, 8'h01);
      wr(MD, 8'h48);
      rd(LO, v1);
      c0 = req_count;
      wr(UP, 8'h5A);
      el = cyc;
      rdchk(UP, 8'h01);
      wait_req(1000);
      el = cyc - el;
      `CHK(el >= 500 - v1 && el <= 514 - v1, 1'b1)
      `CHK(req_count - c0, 1)
      $display("test refresh done, %0d cycles", el);
      do_reset();
      wr(MD, 8'h00);
      wr(MD, 8'h20);
      rdchk(MD, 8'h20);
      wr(MD, 8'h00);
      rdchk(CM, 8'h48);
      xfer(1'b0, 8'h00, 8'h00, r, e);
      `CHK(e, 1'b1)
      `CHK(r, 32'h00000000)
      do_reset();
      rdchk(MD, 8'h40);
      $display("test lock done");
      summarize();
   end

   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      summarize();
   end
endmodule
